// [verilog/sadc_pkg.sv]
// Constants, field layout and state encoding of the SAR converter control.
// Assumes one 40 MHz clock domain; all counts are in cycles of that clock.
package sadc_pkg;
   // Result, channel, bus, counter, index and mode widths
   localparam int RES_W = 10;
   localparam int CH_W = 3;
   localparam int AW = 5;
   localparam int DW = 32;
   localparam int CNT_W = 4;
   localparam int IDX_W = 4;
   localparam int MODE_W = 4;

   // Register byte offsets
   localparam logic [AW-1:0] OFF_MODE = 5'h00;
   localparam logic [AW-1:0] OFF_CHAN = 5'h04;
   localparam logic [AW-1:0] OFF_RES = 5'h08;
   localparam logic [AW-1:0] OFF_STAT = 5'h0c;
   localparam logic [AW-1:0] OFF_IEN = 5'h10;
   localparam logic [AW-1:0] OFF_ICLR = 5'h14;

   // Field positions
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_HW_BIT = 1;
   localparam int MODE_EDGE_LSB = 2;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;

   // Trigger edge encodings
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Values after reset
   localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
   localparam logic [CH_W-1:0] CHAN_RST = 3'h0;
   localparam logic [RES_W-1:0] RES_RST = 10'h000;
   localparam logic IEN_RST = 1'b0;

   // Conversion timing: sampling takes one tenth of the period
   localparam int SAMPLE_CYCLES = 10;
   localparam int CONV_CYCLES = SAMPLE_CYCLES * 10;
   localparam int BIT_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / RES_W;
   localparam logic [CNT_W-1:0] SAMP_LAST = CNT_W'(SAMPLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } sadc_state_type;
endpackage

// [verilog/sadc_sar_if.sv]
// Carrier between the sequencer and the approximation engine.
// Assumes both ends share mclk_i; no crossing takes place here.
`timescale 1ns/100ps
interface sadc_sar_if;
   import sadc_pkg::*;
   logic start; // Begin a fresh conversion, restarts a running one
   logic abort; // Stop the running conversion
   logic done; // One-cycle pulse, result is valid
   logic busy; // Conversion in progress
   logic [RES_W-1:0] result; // Settled code
   modport ctrl (output start, output abort,
                 input done, input busy, input result);
   modport engine (input start, input abort,
                   output done, output busy, output result);
endinterface

// [verilog/sadc_sar.sv]
// Successive approximation engine: sampling phase, then one trial per bit.
// Assumes the comparator input is already synchronised to mclk_i.
`timescale 1ns/100ps
module sadc_sar
   import sadc_pkg::*;
(
   // Clock, reset and enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Comparator, high when input is above the trial tap
   input wire logic comp_i,
   // Sequencer side
   sadc_sar_if.engine sar,
   // Analog front end
   output logic sample_o,
   output logic [RES_W-1:0] dac_o
);
   logic busy_q; // Conversion running
   logic sample_q; // Sampling switch closed
   logic done_q; // Completion pulse
   logic [CNT_W-1:0] cnt_q; // Cycle within phase
   logic [IDX_W-1:0] idx_q; // Bit under trial
   logic [RES_W-1:0] sar_q; // Approximation register
   logic [RES_W-1:0] sar_d;
   logic [RES_W-1:0] res_q; // Latched result

   // Phase end and bit decision strobes
   wire step_end = cnt_q == (sample_q ? SAMP_LAST : BIT_LAST);
   wire samp_end = busy_q && sample_q && step_end;
   wire decide = busy_q && !sample_q && step_end;
   wire last = decide && (idx_q == '0);

   // Per bit: keep or drop on decision, then set the next lower trial
   genvar i;
   generate
      for (i = 0; i < RES_W; i++) begin : g_bit
         wire top_b = (i == RES_W - 1);
         wire own = decide && (idx_q == IDX_W'(i));
         wire nxt = decide && (idx_q == IDX_W'(i + 1));
         assign sar_d[i] = sar.start ? 1'b0 :
                           (samp_end && top_b) ? 1'b1 :
                           own ? comp_i :
                           nxt ? 1'b1 : sar_q[i];
      end
   endgenerate

   // Sequencing of sample and bit phases; start beats abort for restart
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         sample_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= '0;
         idx_q <= '0;
      end else if (ce_i) begin
         if (sar.start) begin
            busy_q <= 1'b1;
            sample_q <= 1'b1;
            done_q <= 1'b0;
            cnt_q <= '0;
            idx_q <= IDX_W'(RES_W - 1);
         end else if (sar.abort || !busy_q) begin
            busy_q <= 1'b0;
            sample_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
         end else begin
            done_q <= last;
            cnt_q <= step_end ? '0 : cnt_q + 1'b1;
            if (samp_end) begin
               sample_q <= 1'b0;
            end else if (last) begin
               busy_q <= 1'b0;
            end else if (decide) begin
               idx_q <= idx_q - 1'b1;
            end
         end
      end
   end

   // Approximation register and all-bits-at-once result transfer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sar_q <= '0;
         res_q <= RES_RST;
      end else if (ce_i) begin
         sar_q <= sar_d;
         // A restart in the last decision cycle must not latch the
         // cleared trial code
         if (last && !sar.start) begin
            res_q <= sar_d;
         end
      end
   end

   assign sar.busy = busy_q;
   assign sar.done = done_q;
   assign sar.result = res_q;
   assign sample_o = sample_q;
   assign dac_o = sar_q;
endmodule

// [verilog/sadc_top.sv]
// Control of a 10-bit SAR converter: bus registers, start sequencing,
// completion conflicts, completion flag and interrupt.
// Assumes an Avalon-MM master on mclk_i; trigger and comparator are
// asynchronous and are synchronised here.
//
// Functional notes
// - Result read wins, new result follows after
// - Triggers ignored while converting or writing result
// - Config write at completion wins, result kept
// - Discarded completion raises no interrupt flag
// - Channel rewrite leaves completion flag untouched
// - Sampling takes a tenth of the period
// - Ten-bit result stored in result register
// - MSB-first approximation, all bits transferred together
// - Software mode converts back to back
// - Hardware mode: one conversion per trigger
// - Config write aborts conversion, restarts it only in enabled software mode
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sadc_top
   import sadc_pkg::*;
(
   // Clock, reset and enable
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Avalon-MM slave
   input wire logic [AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [DW-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [DW-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Asynchronous pins
   input wire logic external_trigger_in_i,
   input wire logic comparator_i,
   // Analog front end
   output logic sample_switch_o,
   output logic [RES_W-1:0] dac_code_o,
   output logic [CH_W-1:0] channel_o,
   // Interrupt
   output logic conversion_end_irq_o
);
   // Carrier to the approximation engine; start and abort go out,
   // done, busy and the settled code come back
   sadc_sar_if sar ();

   // Synchronisers and trigger history
   logic trg_s1_q; // First stage, read by second only
   logic trg_s2_q;
   logic trg_s3_q; // Previous level for edge detect
   logic cmp_s1_q; // First stage, read by second only
   logic cmp_s2_q;

   // Bus handshake
   // waitrequest comes straight from wait_q
   logic wait_q; // Drives waitrequest, high when idle
   logic [DW-1:0] rdata_q; // Read data held to the ack edge

   // Software registers
   // Channel and mode keep their value across stops
   logic [MODE_W-1:0] converter_mode_reg_q;
   logic [MODE_W-1:0] mode_d;
   logic [CH_W-1:0] channel_select_reg_q;
   logic [RES_W-1:0] conversion_result_reg_q;
   logic ien_q; // Interrupt enable
   logic conversion_end_flag_q; // Sticky completion flag
   logic flag_d;
   logic irq_q;

   // Deferred result while a result read is in flight
   // A read of the result has priority over the store
   logic pend_q;
   logic [RES_W-1:0] pend_val_q;

   // Sequencer
   // One-hot states, encoded in the package
   sadc_state_type state_q;
   sadc_state_type state_d;
   logic start_w;

   // Two-flop synchronisers for the pins
   // The third trigger stage keeps the previous level for edge
   // detection; an edge made by reset itself meets the idle
   // sequencer and is dropped
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         trg_s1_q <= 1'b0;
         trg_s2_q <= 1'b0;
         trg_s3_q <= 1'b0;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else if (ce_i) begin
         trg_s1_q <= external_trigger_in_i;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
         cmp_s1_q <= comparator_i;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // Address decode
   // Exact match on all five bits, so no register shows up twice
   wire a_mode = avs_address_i == OFF_MODE;
   wire a_chan = avs_address_i == OFF_CHAN;
   wire a_res = avs_address_i == OFF_RES;
   wire a_stat = avs_address_i == OFF_STAT;
   wire a_ien = avs_address_i == OFF_IEN;
   wire a_iclr = avs_address_i == OFF_ICLR;

   // Handshake: one wait cycle, then the ack edge
   // A fixed single wait state costs one cycle per access but lets the
   // read data come from a flip-flop instead of the address decoder
   wire req = avs_read_i || avs_write_i;
   wire rd_take = avs_read_i && wait_q;
   // Writes act only on the ack edge and need the low byte lane
   wire wr_fire = avs_write_i && !wait_q && avs_byteenable_i[0];
   wire cfg_wr = wr_fire && (a_mode || a_chan);
   // A read of the result is in flight until its ack edge has passed
   // Byte enables do not qualify reads
   wire rd_res = avs_read_i && a_res;

   // New mode value, as seen by the sequencer in the write cycle
   // Using the stored value would restart with the old enable and
   // start source for one conversion
   assign mode_d = (wr_fire && a_mode) ?
                   avs_writedata_i[MODE_W-1:0] : converter_mode_reg_q;
   wire en_d = mode_d[MODE_EN_BIT];
   wire hw_d = mode_d[MODE_HW_BIT];
   wire [1:0] edge_sel = converter_mode_reg_q[MODE_EDGE_LSB +: 2];

   // Trigger edge by selected polarity
   // Edge code zero matches nothing: hardware mode then stays waiting
   // until software writes a new mode
   wire rise = trg_s2_q && !trg_s3_q;
   wire fall = !trg_s2_q && trg_s3_q;
   wire trig_edge = ((edge_sel == EDGE_RISE) && rise) ||
                    ((edge_sel == EDGE_FALL) && fall) ||
                    ((edge_sel == EDGE_BOTH) && (rise || fall));

   // Completion conflict: configuration write wins
   // The write aborts the engine in the same edge, so the code that
   // would have been stored belongs to the old setting and is dropped
   wire done_ok = sar.done && !cfg_wr;
   // Result read wins; result goes in once the read is served
   wire commit = (done_ok || pend_q) && !rd_res;
   wire [RES_W-1:0] commit_val = pend_q ? pend_val_q : sar.result;
   // Writing one to bit zero of the clear register drops the flag
   wire flag_clr = wr_fire && a_iclr && avs_writedata_i[STAT_FLAG_BIT];

   // Read data selection; unmapped and write-only read as zero
   // Data are taken at the wait edge, so a status change in the ack
   // cycle shows only on the next read
   wire [DW-1:0] rd_mux =
      a_mode ? DW'(converter_mode_reg_q) :
      a_chan ? DW'(channel_select_reg_q) :
      a_res ? DW'(conversion_result_reg_q) :
      a_stat ? DW'({sar.busy, conversion_end_flag_q}) :
      a_ien ? DW'(ien_q) : '0;

   // Bus slave: wait, ack for one cycle, drop back to waiting
   // A request still high after its ack is seen as a new one, which
   // is how back-to-back accesses are served
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else if (ce_i) begin
         wait_q <= !(req && wait_q);
         if (rd_take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Mode, channel and interrupt enable registers
   // Only byte lane zero carries fields, so it alone gates a write
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         converter_mode_reg_q <= MODE_RST;
         channel_select_reg_q <= CHAN_RST;
         ien_q <= IEN_RST;
      end else if (ce_i) begin
         // Writes take effect even against a completion
         converter_mode_reg_q <= mode_d;
         if (wr_fire && a_chan) begin
            channel_select_reg_q <= avs_writedata_i[CH_W-1:0];
         end
         if (wr_fire && a_ien) begin
            ien_q <= avs_writedata_i[0];
         end
      end
   end

   // Sticky flag: set beats clear, channel writes do not touch it
   // A clear that meets a completion is lost on purpose: dropping the
   // new completion would hide a result from software
   assign flag_d = commit || (conversion_end_flag_q && !flag_clr);

   // Result register, deferral and completion flag
   // Only one code can wait; the next completion is a full conversion
   // away, far longer than any single read stays in flight
   // The interrupt follows the flag one cycle late, from a flip-flop
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         conversion_result_reg_q <= RES_RST;
         pend_q <= 1'b0;
         pend_val_q <= RES_RST;
         conversion_end_flag_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce_i) begin
         if (commit) begin
            conversion_result_reg_q <= commit_val;
            pend_q <= 1'b0;
         end else if (done_ok) begin
            // Hold the fresh code until the read is over
            pend_q <= 1'b1;
            pend_val_q <= sar.result;
         end
         // Only stored results set it, so discarded ones stay silent
         conversion_end_flag_q <= flag_d;
         irq_q <= conversion_end_flag_q && ien_q;
      end
   end

   // Sequencer next state and start request
   // Waiting is the only state that looks at trigger edges; the
   // running state leaves only on completion or a config write
   always_comb begin
      state_d = state_q;
      start_w = 1'b0;
      if (cfg_wr) begin
         // Any config write reinitialises the conversion
         if (!en_d) begin
            state_d = ST_IDLE;
         end else if (hw_d) begin
            state_d = ST_WAIT;
         end else begin
            state_d = ST_RUN;
            start_w = 1'b1;
         end
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_d = ST_IDLE;
            end
            ST_WAIT: begin
               // Only waiting accepts an edge
               if (trig_edge) begin
                  state_d = ST_RUN;
                  start_w = 1'b1;
               end
            end
            ST_RUN: begin
               // Edges are ignored here, also in the store cycle
               if (sar.done && hw_d) begin
                  state_d = ST_WAIT;
               end else if (sar.done) begin
                  start_w = 1'b1;
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // Sequencer state register
   // Frozen with the rest of the block while ce_i is low
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // Abort on any config write; a restart rides on start
   // The engine gives start priority, so abort plus start restarts
   // from the sampling phase instead of stopping
   assign sar.start = start_w;
   assign sar.abort = cfg_wr;

   // Approximation engine
   // It sees only the synchronised comparator, never the raw pin
   sadc_sar sadc_sar_inst (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .comp_i(cmp_s2_q),
      .sar(sar),
      .sample_o(sample_switch_o),
      .dac_o(dac_code_o)
   );

   // Outputs from flip-flops
   // No output passes through logic after its register
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign channel_o = channel_select_reg_q;
   assign conversion_end_irq_o = irq_q;
endmodule

// [testbench/sadc_chk_sva.sv]
// Port-level checker of the converter control, bound into sadc_top.
// Assumes ce_i is held high; every figure is in mclk_i cycles.
`timescale 1ns/100ps
module sadc_chk
   import sadc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register bus
   input wire logic [AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [DW-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [DW-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Converter outputs
   input wire logic sample_switch_o,
   input wire logic [RES_W-1:0] dac_code_o,
   input wire logic conversion_end_irq_o
);
   // Accepted accesses; byte lane 0 gates every write
   wire logic wr_ack = avs_write_i && !avs_waitrequest_o
      && avs_byteenable_i[0];
   wire logic rd_ack = avs_read_i && !avs_waitrequest_o;
   wire logic wr_mode = wr_ack && avs_address_i == OFF_MODE;
   wire logic wr_cfg = wr_mode || (wr_ack && avs_address_i == OFF_CHAN);
   logic [4:0] samp_q; // Cycles of the current sampling phase
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Count sampling cycles; a config write restarts the phase
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         samp_q <= 5'h00;
      end else if (!sample_switch_o || wr_cfg) begin
         samp_q <= 5'h00;
      end else if (samp_q != 5'h1f) begin
         samp_q <= samp_q + 5'h01;
      end
   end
   AST_ONE_WAIT: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");
   AST_WAIT_PULSE: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   AST_SAMPLE_LEN: assert property (
      $fell(sample_switch_o) && !$past(wr_cfg)
      |-> samp_q >= 5'h09 && samp_q <= 5'h0a)
      else $error("sampling phase not a tenth of the conversion");
   AST_MSB_TRIAL: assert property (
      $fell(sample_switch_o) && !$past(wr_cfg) |-> dac_code_o == 10'h200)
      else $error("first trial after sampling is not the top bit");
   AST_RESTART: assert property (
      wr_mode && avs_writedata_i[1:0] == 2'h1 |-> ##[1:2] sample_switch_o)
      else $error("software start did not begin sampling");
   AST_STOP: assert property (
      wr_mode && !avs_writedata_i[MODE_EN_BIT]
      |-> ##2 !sample_switch_o [*4])
      else $error("conversion kept running after stop");
   AST_IRQ_MASK: assert property (
      wr_ack && avs_address_i == OFF_IEN && !avs_writedata_i[0]
      |-> ##2 !conversion_end_irq_o)
      else $error("interrupt stays high after masking");
   AST_RD_UNMAPPED: assert property (
      rd_ack && (avs_address_i > OFF_IEN || avs_address_i[1:0] != 2'h0)
      |-> avs_readdata_o == '0)
      else $error("unmapped or write-only read not zero");
   AST_RD_WIDTH: assert property (
      rd_ack |-> avs_readdata_o[DW-1:RES_W] == '0)
      else $error("read data above bit nine not zero");
endmodule
bind sadc_top sadc_chk sadc_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .sample_switch_o(sample_switch_o), .dac_code_o(dac_code_o),
   .conversion_end_irq_o(conversion_end_irq_o));

// [testbench/sadc_far_end.sv]
// Far side model: analog source seen through the comparator, trigger pin.
// Assumes the trial code on dac_i is the tap the comparator compares.
`timescale 1ns/100ps
module sadc_far_end
   import sadc_pkg::*;
(
   // Clock that times pin changes
   input wire logic mclk_i,
   // Trial code from the block
   input wire logic [RES_W-1:0] dac_i,
   // Pins into the block
   output logic comp_o,
   output logic trig_o
);
   logic [RES_W-1:0] vin = 10'h000; // Input level in result steps
   // Input at or above the tap keeps the trial bit
   assign comp_o = vin >= dac_i;
   initial trig_o = 1'b0;
   // Source moves just after an edge, never mid-cycle
   task automatic set_vin(input logic [RES_W-1:0] v);
      @(posedge mclk_i);
      vin <= v;
   endtask
   // Trigger pin level; its edges are all the block sees
   task automatic drive_trig(input logic lvl);
      @(posedge mclk_i);
      trig_o <= lvl;
   endtask
endmodule

// [testbench/test_sar_adc_sequencing_arbitration.sv]
// Self-checking bench of the converter control with its far side model.
// Assumes one 40 MHz clock; ce_i is held high for the whole run.
`timescale 1ns/100ps
module test_sar_adc_sequencing_arbitration import sadc_pkg::*; ;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [AW-1:0] avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [DW-1:0] avs_writedata_i = '0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [DW-1:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic trig_pin, comp_pin, sample_switch_o, conversion_end_irq_o;
   logic [RES_W-1:0] dac_code_o;
   logic [CH_W-1:0] channel_o;
   int err_count = 0;
   int compares = 0;
   int cyc = 0; // Edge count, used to aim an access at a completion
   always #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= cyc + 1;
   sadc_top sadc_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .external_trigger_in_i(trig_pin), .comparator_i(comp_pin),
      .sample_switch_o(sample_switch_o), .dac_code_o(dac_code_o),
      .channel_o(channel_o), .conversion_end_irq_o(conversion_end_irq_o));
   sadc_far_end sadc_far_end_inst (.mclk_i(mclk_i), .dac_i(dac_code_o),
      .comp_o(comp_pin), .trig_o(trig_pin));
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [AW-1:0] a,
      input logic [DW-1:0] d, input logic [3:0] be, output logic [DW-1:0] q);
      int n = 0;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 40);
      q = avs_readdata_o;
      check(avs_waitrequest_o, 0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic [DW-1:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] m,
      input logic [DW-1:0] e);
      logic [DW-1:0] q;
      bus(1'b0, a, '0, 4'hf, q);
      check(q & m, e);
   endtask
   // Bounded wait for the interrupt; stale level is let go first
   task automatic wait_irq(input int lim);
      int n = 0;
      repeat (3) @(posedge mclk_i);
      #1;
      while (conversion_end_irq_o !== 1'b1 && n < lim) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      check(conversion_end_irq_o, 1);
   endtask
   task automatic t_reset;
      logic [DW-1:0] q;
      rd(OFF_MODE, '1, 0);
      rd(OFF_STAT, '1, 0);
      rd(5'h18, '1, 0);
      bus(1'b1, OFF_CHAN, 32'h7, 4'he, q);
      wr(OFF_RES, 32'h3ff);
      rd(OFF_CHAN, '1, 0);
      rd(OFF_RES, '1, 0);
      $display("reset test done");
   endtask
   task automatic t_soft;
      sadc_far_end_inst.set_vin(10'h2a5);
      wr(OFF_IEN, 1);
      wr(OFF_MODE, 1);
      wait_irq(300);
      wr(OFF_ICLR, 1);
      wait_irq(300);
      rd(OFF_RES, '1, 32'h2a5);
      wr(OFF_IEN, 0);
      repeat (3) @(posedge mclk_i);
      #1 check(conversion_end_irq_o, 0);
      wr(OFF_CHAN, 5);
      rd(OFF_STAT, 3, 3);
      check(channel_o, 5);
      wr(OFF_IEN, 1);
      $display("software start test done");
   endtask
   // Aims a read or a channel write at the cycle a conversion completes
   task automatic t_hit(input logic is_rd, input logic [DW-1:0] was,
      input logic [RES_W-1:0] nv);
      logic [DW-1:0] q;
      int t0;
      while (sample_switch_o !== 1'b0) begin
         @(posedge mclk_i);
         #1;
      end
      while (sample_switch_o !== 1'b1) begin
         @(posedge mclk_i);
         #1;
      end
      t0 = cyc;
      wr(OFF_ICLR, 1);
      sadc_far_end_inst.set_vin(nv);
      // Ack must land on the edge at which the engine shows done
      while (cyc < t0 + 98) begin
         @(posedge mclk_i);
         #1;
      end
      bus(!is_rd, is_rd ? OFF_RES : OFF_CHAN, 32'h2, 4'hf, q);
      repeat (3) @(posedge mclk_i);
      #1;
      if (is_rd) begin
         check(q, was);
         rd(OFF_STAT, 1, 1);
         rd(OFF_RES, '1, nv);
      end else begin
         check(conversion_end_irq_o, 0);
         check(channel_o, 2);
         rd(OFF_STAT, 1, 0);
         rd(OFF_RES, '1, was);
         wait_irq(300);
         rd(OFF_RES, '1, nv);
      end
      $display("completion conflict test done");
   endtask
   // One conversion per valid trigger edge; edges while busy are lost
   task automatic t_hw(input logic [1:0] e);
      wr(OFF_MODE, 0);
      sadc_far_end_inst.drive_trig(e == EDGE_FALL);
      wr(OFF_ICLR, 1);
      wr(OFF_MODE, {28'h0, e, 2'h3});
      repeat (150) @(posedge mclk_i);
      rd(OFF_STAT, 3, 0);
      sadc_far_end_inst.drive_trig(e != EDGE_FALL);
      repeat (20) @(posedge mclk_i);
      sadc_far_end_inst.drive_trig(e == EDGE_FALL);
      sadc_far_end_inst.drive_trig(e != EDGE_FALL);
      wait_irq(92);
      wr(OFF_ICLR, 1);
      repeat (200) @(posedge mclk_i);
      rd(OFF_STAT, 3, 0);
      $display("hardware start test done");
   endtask
   task automatic close_out;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_reset;
      t_soft;
      t_hit(1'b0, 32'h2a5, 10'h15a);
      t_hit(1'b1, 32'h15a, 10'h0f3);
      t_hw(EDGE_RISE);
      t_hw(EDGE_FALL);
      t_hw(EDGE_BOTH);
      close_out;
   end
   // Watchdog, about fourteen times the expected run
   initial begin
      repeat (30000) @(posedge mclk_i);
      err_count++;
      close_out;
   end
endmodule
